/* hdl/flash_prog_pkg.sv */
// Constants and types shared by the flash programming access port
package flash_prog_pkg;
    // ****************************************
    // Command framing
    // ****************************************
    localparam logic [7:0] PREAMBLE_BYTE  = 8'haa;
    localparam logic [7:0] CMD_READ_STAT  = 8'h60;
    localparam logic [7:0] CMD_WRITE_FUSE = 8'he1;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;
    localparam int         BYTE_BITS      = 8;
    localparam int         ISP_FUSE_BIT   = 0;
    localparam logic [2:0] BIT_LAST       = 3'h7;
    localparam logic [1:0] IDX_FIRST      = 2'h0;
    localparam logic [1:0] IDX_CMD        = 2'h1;
    localparam logic [1:0] IDX_ADDR_HI    = 2'h2;
    localparam logic [1:0] IDX_ADDR_LO    = 2'h3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_MHZ     = 20;
    localparam int BUSY_TIME_US  = 3;
    localparam int BUSY_CYCLES   = (BUSY_TIME_US * CLOCK_MHZ < 1) ? 1 : BUSY_TIME_US * CLOCK_MHZ;

    typedef enum logic [1:0] {
        PAR_IDLE  = 2'b00,
        PAR_HEAD  = 2'b01,
        PAR_DRIVE = 2'b10,
        PAR_DONE  = 2'b11
    } par_state_t;
endpackage

/* hdl/byte_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Pointer wrap arithmetic only works for power-of-two depths
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_params
        $error("byte_fifo needs a power-of-two depth of at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem_q[rd_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule

/* hdl/flash_prog_port.sv */
// Device side of the flash programming access port: parallel status read and serial ISP
`timescale 1ns/1ps
// Functional notes
// R1: Status request is preamble, 0x60, two zero bytes, each taken on strobe high.
// R2: Programmer releases data port on last byte, reads status after strobe falls.
// R3: Programmer waits 3 us after busy returns high before next operation.
// R4: Serial mode accepts the same command set, bytes arriving over SPI pins.
// R5: Serial sessions are refused unless the serial enable fuse is set.
// R6: Fuse changes by a serial session take effect only after power cycle.
// R7: Only the parallel interface can set the serial enable fuse again.
// R8: Programmer powers up with clock and select low, then raises reset and select.
// R9: Programmer waits 2 ms after reset rises before any command.
// R10: Programmer powers down releasing data, then clock, reset, select low.
// R11: Programmer enters ISP: select high, release output, reset high, clock low.
// R12: Programmer exits ISP: select high, release lines, reset low, release select.
// R13: Every serial byte moves most significant bit first.
// R14: Device shifts output on falling clock, samples input on rising clock.
// R15: Select frames a command; it completes only when select rises.
// R16: Commands enter on master-out; responses leave on master-in.
// R17: Programmer waits, watches busy, or polls status after a write.
// R18: Serial output is released whenever select is high.
module flash_prog_port
    import flash_prog_pkg::*;
#(
    parameter int          FIFO_DEPTH = 4,
    parameter logic [7:0]  FUSE_INIT  = 8'hff
) (
    // Clock, reset and supply
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       power_on,
    // Parallel port
    input  wire logic       cs_n,
    input  wire logic       strobe_pin,
    input  wire logic [7:0] parallel_data_port_in,
    output logic [7:0]      parallel_data_port_out,
    output logic            parallel_data_port_oe_n,
    output logic            busy_output_pin,
    // Serial in_system_programming port
    input  wire logic       sck,
    input  wire logic       ss_n,
    input  wire logic       mosi,
    output logic            miso_out,
    output logic            miso_oe_n,
    // Command stream towards the flash core, busy and status back from it
    output logic            cmd_valid,
    output logic [7:0]      cmd_byte,
    output logic            cmd_end,
    input  wire logic       cmd_ready,
    input  wire logic       core_busy,
    input  wire logic [7:0] status_byte,
    // Fuse state
    output logic            isp_enabled
);
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("flash_prog_port needs a power-of-two FIFO_DEPTH of at least 2");
    end

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [1:0] cs_s_q;
    logic [1:0] stb_s_q;
    logic [1:0] sck_s_q;
    logic [1:0] ss_s_q;
    logic [1:0] mosi_s_q;
    logic [1:0] busy_s_q;
    logic [1:0] pwr_s_q;
    logic [7:0] pd_s1_q;
    logic [7:0] pd_s2_q;
    logic       stb_prev_q;
    logic       sck_prev_q;
    logic       ss_prev_q;

    always_ff @(posedge clock) begin
        cs_s_q   <= {cs_s_q[0], cs_n};
        stb_s_q  <= {stb_s_q[0], strobe_pin};
        sck_s_q  <= {sck_s_q[0], sck};
        ss_s_q   <= {ss_s_q[0], ss_n};
        mosi_s_q <= {mosi_s_q[0], mosi};
        busy_s_q <= {busy_s_q[0], core_busy};
        pwr_s_q  <= {pwr_s_q[0], power_on};
        pd_s1_q  <= parallel_data_port_in;
        pd_s2_q  <= pd_s1_q;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stb_prev_q  <= 1'b0;
            sck_prev_q  <= 1'b0;
            ss_prev_q   <= 1'b1;
        end else begin
            stb_prev_q  <= stb_s_q[1];
            sck_prev_q  <= sck_s_q[1];
            ss_prev_q   <= ss_s_q[1];
        end
    end

    logic stb_rise;
    logic stb_fall;
    logic sck_rise;
    logic sck_fall;
    logic ss_fall;
    logic ss_rise;
    assign stb_rise = stb_s_q[1] && !stb_prev_q;
    assign stb_fall = !stb_s_q[1] && stb_prev_q;
    assign sck_rise = sck_s_q[1] && !sck_prev_q;
    assign sck_fall = !sck_s_q[1] && sck_prev_q;
    assign ss_fall  = !ss_s_q[1] && ss_prev_q;
    assign ss_rise  = ss_s_q[1] && !ss_prev_q;

    // ****************************************
    // Fuse: live copy and power-on snapshot
    // ****************************************
    // The serial mode is gated by the snapshot, so a serial fuse write only bites after power cycling
    logic [7:0] fuse_q;
    logic       isp_en_q;
    logic       pwr_prev_q;
    logic       fuse_wr_serial;
    logic       fuse_wr_par;
    logic [7:0] fuse_wr_data;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fuse_q     <= FUSE_INIT;
            isp_en_q   <= 1'b0;
            pwr_prev_q <= 1'b0;
        end else begin
            pwr_prev_q <= pwr_s_q[1];
            if (pwr_s_q[1] && !pwr_prev_q)
                isp_en_q <= fuse_q[ISP_FUSE_BIT];                       // R6
            if (fuse_wr_par)
                fuse_q <= fuse_wr_data;                                 // R7
            else if (fuse_wr_serial)
                fuse_q <= fuse_wr_data & ~(8'h01 << ISP_FUSE_BIT) | (fuse_q & (8'h01 << ISP_FUSE_BIT)
                          & fuse_wr_data);                              // R7
        end
    end
    assign isp_enabled = isp_en_q;

    // ****************************************
    // Parallel command decoder
    // ****************************************
    par_state_t pst_q;
    logic [1:0] pidx_q;
    logic [7:0] pcmd_q;
    logic       p_valid;
    logic       p_end;

    always_ff @(posedge clock) begin
        if (!rst_n || cs_s_q[1]) begin
            pst_q  <= PAR_IDLE;
            pidx_q <= IDX_FIRST;
            pcmd_q <= ZERO_BYTE;
        end else begin
            case (pst_q)
                PAR_IDLE: begin
                    if (stb_rise) begin
                        pst_q  <= (pd_s2_q == PREAMBLE_BYTE) ? PAR_HEAD : PAR_DONE; // R1
                        pidx_q <= IDX_CMD;
                    end
                end
                PAR_HEAD: begin
                    if (stb_rise) begin
                        if (pidx_q == IDX_CMD)
                            pcmd_q <= pd_s2_q;
                        pidx_q <= pidx_q + 2'h1;
                        if (pidx_q == IDX_ADDR_LO && pcmd_q == CMD_READ_STAT)
                            pst_q <= PAR_DRIVE;                         // R1
                    end
                end
                PAR_DRIVE: pst_q <= PAR_DRIVE;
                PAR_DONE:  pst_q <= PAR_DONE;
                default:   pst_q <= PAR_IDLE;
            endcase
        end
    end
    // A frame that does not open with the preamble leaves nothing in the stream
    assign p_valid = stb_rise && (pst_q == PAR_HEAD || pst_q == PAR_DRIVE
                     || (pst_q == PAR_IDLE && pd_s2_q == PREAMBLE_BYTE));   // R1
    assign p_end   = cs_s_q[1] && pst_q != PAR_IDLE;
    assign fuse_wr_par = stb_rise && pst_q == PAR_HEAD && pidx_q == IDX_ADDR_LO && pcmd_q == CMD_WRITE_FUSE; // R7

    // Status is driven only after the strobe falls, once the programmer has released the port
    always_ff @(posedge clock) begin
        if (!rst_n || cs_s_q[1]) begin
            parallel_data_port_oe_n <= 1'b1;
            parallel_data_port_out  <= ZERO_BYTE;
        end else if (pst_q == PAR_DRIVE && stb_fall) begin
            parallel_data_port_oe_n <= 1'b0;                            // R2
            parallel_data_port_out  <= status_byte;
        end
    end

    // ****************************************
    // Serial shifter
    // ****************************************
    logic [7:0] sin_q;
    logic [2:0] sbit_q;
    logic [7:0] sout_q;
    logic       s_active;
    logic       s_byte;
    logic [1:0] sidx_q;
    logic [7:0] scmd_q;

    assign s_active = !ss_s_q[1] && isp_en_q;                           // R5
    assign s_byte   = s_active && sck_rise && sbit_q == BIT_LAST;

    always_ff @(posedge clock) begin
        if (!rst_n || !s_active) begin
            sin_q  <= ZERO_BYTE;
            sbit_q <= '0;
        end else if (sck_rise) begin
            sin_q  <= {sin_q[6:0], mosi_s_q[1]};                        // R13 R16
            sbit_q <= sbit_q + 3'h1;                                    // R14
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || !s_active) begin
            sidx_q <= IDX_FIRST;
            scmd_q <= ZERO_BYTE;
        end else if (s_byte) begin
            if (sidx_q == IDX_CMD)
                scmd_q <= {sin_q[6:0], mosi_s_q[1]};
            if (sidx_q != IDX_ADDR_LO)
                sidx_q <= sidx_q + 2'h1;
        end
    end
    assign fuse_wr_serial = s_byte && sidx_q == IDX_ADDR_LO && scmd_q == CMD_WRITE_FUSE;
    assign fuse_wr_data   = fuse_wr_par ? pd_s2_q : {sin_q[6:0], mosi_s_q[1]};

    // Response loads after the address bytes and moves out on falling edges
    always_ff @(posedge clock) begin
        if (!rst_n || !s_active) begin
            sout_q    <= ZERO_BYTE;
            miso_out  <= 1'b0;
            miso_oe_n <= 1'b1;                                          // R18
        end else begin
            miso_oe_n <= 1'b0;                                          // R16
            if (s_byte && sidx_q == IDX_ADDR_LO && scmd_q == CMD_READ_STAT)
                sout_q <= status_byte;                                  // R4
            else if (sck_fall) begin
                miso_out <= sout_q[BYTE_BITS-1];                        // R13 R14
                sout_q   <= {sout_q[6:0], 1'b0};
            end
        end
    end

    // ****************************************
    // Command stream through the FIFO
    // ****************************************
    logic       f_in_valid;
    logic       f_in_ready;
    logic [8:0] f_in_data;
    logic       f_out_valid;
    logic [8:0] f_out_data;
    logic       s_end;

    // A select pulse without clocks carries no command, so it adds no end marker
    assign s_end      = ss_rise && isp_en_q && (sidx_q != IDX_FIRST || sbit_q != '0); // R15
    assign f_in_valid = p_valid || s_byte || ((p_end || s_end) && pst_q != PAR_DONE);
    assign f_in_data  = (p_end || s_end) ? {1'b1, ZERO_BYTE}
                        : {1'b0, s_byte ? {sin_q[6:0], mosi_s_q[1]} : pd_s2_q}; // R4

    byte_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (cmd_ready || !cmd_valid),
        .out_data  (f_out_data)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cmd_valid <= 1'b0;
            cmd_byte  <= ZERO_BYTE;
            cmd_end   <= 1'b0;
        end else if (cmd_ready || !cmd_valid) begin
            cmd_valid <= f_out_valid;
            cmd_byte  <= f_out_data[7:0];
            cmd_end   <= f_out_data[8];
        end
    end

    // Busy pin also reports a full FIFO so the programmer backs off
    always_ff @(posedge clock) begin
        if (!rst_n)
            busy_output_pin <= 1'b1;
        else
            busy_output_pin <= !busy_s_q[1] && f_in_ready;              // R17
    end
endmodule

/* bench/flash_prog_port_properties.sv */
// Pin-level checks for the flash programming port
`timescale 1ns/1ps
module flash_prog_port_properties
    import flash_prog_pkg::*;
(
    // Clock, reset and supply
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       power_on,
    // Programming pins
    input wire logic       cs_n,
    input wire logic       strobe_pin,
    input wire logic [7:0] parallel_data_port_out,
    input wire logic       parallel_data_port_oe_n,
    input wire logic       busy_output_pin,
    input wire logic       sck,
    input wire logic       ss_n,
    input wire logic       miso_out,
    input wire logic       miso_oe_n,
    // Core side
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic       cmd_end,
    input wire logic       cmd_ready,
    input wire logic       core_busy,
    input wire logic [7:0] status_byte,
    input wire logic       isp_enabled
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ****
    // Cycles since the supply monitor last rose, saturating
    // ****
    logic [3:0] since_pwr_q;
    always_ff @(posedge clock) begin
        if (!rst_n || !power_on) since_pwr_q <= 4'h0;
        else if (since_pwr_q != 4'hf) since_pwr_q <= since_pwr_q + 4'h1;
    end
    sequence ss_idle; ss_n [*5]; endsequence
    sequence cs_idle; cs_n [*5]; endsequence
    miso_release_a:
        assert property (ss_idle |-> miso_oe_n) else $error("miso driven while deselected");
    miso_refuse_a:
        assert property (!isp_enabled |=> miso_oe_n) else $error("miso driven with fuse off");
    port_release_a:
        assert property (cs_idle |-> parallel_data_port_oe_n) else $error("port driven after cs high");
    drive_start_a:
        assert property ($fell(parallel_data_port_oe_n) |-> !cs_n && !$past(strobe_pin, 2))
        else $error("port driven before strobe fell");
    drive_value_a:
        assert property (!parallel_data_port_oe_n |-> parallel_data_port_out == status_byte)
        else $error("port shows wrong status");
    miso_edge_a:
        assert property ($changed(miso_out) && !miso_oe_n |-> !$past(sck, 2)) else $error("miso moved off falling sck");
    busy_pin_a:
        assert property (core_busy [*4] |-> !busy_output_pin) else $error("busy pin high while core busy");
    fuse_effect_a:
        assert property ($changed(isp_enabled) |-> since_pwr_q < 4'h8) else $error("fuse took effect without power cycle");
    stream_hold_a:
        assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_byte) && $stable(cmd_end))
        else $error("stream word dropped while stalled");
    end_marker_a:
        assert property (cmd_valid && cmd_end |-> cmd_byte == ZERO_BYTE && cs_n && ss_n)
        else $error("end marker while selected");
endmodule
bind flash_prog_port flash_prog_port_properties flash_prog_port_properties_i (.clock, .rst_n, .power_on,
    .cs_n, .strobe_pin, .parallel_data_port_out, .parallel_data_port_oe_n, .busy_output_pin, .sck, .ss_n,
    .miso_out, .miso_oe_n, .cmd_valid, .cmd_byte, .cmd_end, .cmd_ready, .core_busy, .status_byte, .isp_enabled);

/* bench/isp_programmer.sv */
// Behavioural programmer on the parallel and serial programming pins
`timescale 1ns/1ps
module isp_programmer (
    // Clock
    input  wire logic       clock,
    // Parallel pins
    output logic            cs_n,
    output logic            strobe_pin,
    output logic [7:0]      port_out,
    output logic            port_drive,
    input  wire logic [7:0] port_line,
    // Serial pins
    output logic            sck,
    output logic            ss_n,
    output logic            mosi,
    input  wire logic       miso_line,
    // Read-back report
    output logic [7:0]      rd_byte,
    output logic            rd_stb
);
    initial begin
        cs_n = 1'b1;
        strobe_pin = 1'b0;
        port_out = 8'h00;
        port_drive = 1'b1;
        ss_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
        rd_byte = 8'h00;
        rd_stb = 1'b0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    // Serial pins parked low around supply changes; select rises once supply is up
    task automatic park(input logic sel_high);
        sck = 1'b0;
        mosi = 1'b0;
        ss_n = sel_high;
    endtask
    task automatic pulse_rd(input logic [7:0] b);
        rd_byte = b;
        rd_stb = 1'b1;
        wait_cyc(1);
        rd_stb = 1'b0;
    endtask
    // Port is let go late in the last strobe, since the device takes bytes a few cycles in
    task automatic par_frame(input logic [31:0] bytes, input logic rd);
        cs_n = 1'b0;
        for (int i = 3; i >= 0; i--) begin
            port_out = bytes[i*8 +: 8];
            wait_cyc(2);
            strobe_pin = 1'b1;
            wait_cyc(4);
            if (i == 0 && rd) port_drive = 1'b0;
            wait_cyc(1);
            strobe_pin = 1'b0;
            wait_cyc(6);
        end
        if (rd) pulse_rd(port_line);
        cs_n = 1'b1;
        wait_cyc(4);
        port_drive = 1'b1;
    endtask
    // Serial clock runs only inside a frame, out of phase with the system clock
    task automatic spi_frame(input logic [39:0] bytes, input int n);
        logic [7:0] rx;
        rx = 8'h00;
        ss_n = 1'b0;
        #137;
        for (int i = n - 1; i >= 0; i--) begin
            for (int b = 7; b >= 0; b--) begin
                mosi = bytes[i*8 + b];
                #200 sck = 1'b1;
                rx[b] = miso_line;
                #200 sck = 1'b0;
            end
        end
        mosi = ~mosi;
        #137 ss_n = 1'b1;
        wait_cyc(4);
        if (n == 5) pulse_rd(rx);
    endtask
endmodule

/* bench/tb_flash_prog_port.sv */
// Self-checking bench for the flash programming port
`timescale 1ns/1ps
module tb_flash_prog_port;
    import flash_prog_pkg::*;
    logic       clock, rst_n, power_on, cmd_ready, core_busy;
    logic [7:0] status_byte, port_out, rd_byte, parallel_data_port_out, cmd_byte;
    logic       cs_n, strobe_pin, port_drive, sck, ss_n, mosi, rd_stb, miso_last_q;
    logic       parallel_data_port_oe_n, busy_output_pin, miso_out, miso_oe_n, cmd_valid, cmd_end, isp_enabled;
    wire  [7:0] port_line;
    wire        miso_line;
    logic [8:0] exp_cmd[$];
    logic [7:0] exp_rd[$];
    int         n_mismatch = 0;
    int         tests_run = 0;
    // Released lines show the inverse of their last value
    assign port_line = !parallel_data_port_oe_n ? parallel_data_port_out : (port_drive ? port_out : ~port_out);
    assign miso_line = miso_oe_n ? ~miso_last_q : miso_out;
    always @(posedge clock) if (!miso_oe_n) miso_last_q <= miso_out;
    flash_prog_port #(.FIFO_DEPTH(4)) flash_prog_port_i (.clock(clock), .rst_n(rst_n), .power_on(power_on),
        .cs_n(cs_n), .strobe_pin(strobe_pin), .parallel_data_port_in(port_line),
        .parallel_data_port_out(parallel_data_port_out), .parallel_data_port_oe_n(parallel_data_port_oe_n),
        .busy_output_pin(busy_output_pin), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso_out(miso_out),
        .miso_oe_n(miso_oe_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_end(cmd_end),
        .cmd_ready(cmd_ready), .core_busy(core_busy), .status_byte(status_byte), .isp_enabled(isp_enabled));
    isp_programmer isp_programmer_i (.clock(clock), .cs_n(cs_n), .strobe_pin(strobe_pin), .port_out(port_out),
        .port_drive(port_drive), .port_line(port_line), .sck(sck), .ss_n(ss_n), .mosi(mosi),
        .miso_line(miso_line), .rd_byte(rd_byte), .rd_stb(rd_stb));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ****
    // Result watcher: oldest note against each result
    // ****
    always @(posedge clock) begin
        if (rst_n && cmd_valid && cmd_ready) check("cmd", {cmd_end, cmd_byte}, exp_cmd.pop_front());
        if (rd_stb) check("read", {1'b0, rd_byte}, {1'b0, exp_rd.pop_front()});
    end
    always @(posedge clock) #2 cmd_ready = ($urandom_range(0, 3) != 0);
    task automatic push_frame(input logic [39:0] b, input int n);
        for (int i = n - 1; i >= 0; i--) exp_cmd.push_back({1'b0, b[i*8 +: 8]});
        exp_cmd.push_back({1'b1, ZERO_BYTE});
    endtask
    task automatic drain;
        for (int k = 0; k < 400 && exp_cmd.size() != 0; k++) @(posedge clock);
        #2;
    endtask
    task automatic power_cycle;
        isp_programmer_i.park(1'b0);
        power_on = 1'b0;
        repeat (4) @(posedge clock);
        #2 power_on = 1'b1;
        repeat (200) @(posedge clock);
        #2 isp_programmer_i.park(1'b1);
        repeat (8) @(posedge clock);
        #2;
    endtask
    task automatic new_status;
        status_byte = 8'($urandom);
        exp_rd.push_back(status_byte);
    endtask
    initial begin
        #2_500_000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        power_on = 1'b0;
        core_busy = 1'b0;
        status_byte = 8'h00;
        cmd_ready = 1'b1;
        void'($urandom(17160));
        repeat (5) @(posedge clock);
        #2 rst_n = 1'b1;
        check("isp_rst", {8'h00, isp_enabled}, 9'h000);
        power_cycle();
        check("isp_on", {8'h00, isp_enabled}, 9'h001);
        repeat (40_000) @(posedge clock);
        #2;
        new_status();
        push_frame({8'h00, PREAMBLE_BYTE, CMD_READ_STAT, ZERO_BYTE, ZERO_BYTE}, 4);
        isp_programmer_i.par_frame({PREAMBLE_BYTE, CMD_READ_STAT, ZERO_BYTE, ZERO_BYTE}, 1'b1);
        drain();
        // A frame without the preamble must leave nothing behind
        isp_programmer_i.par_frame({8'h55, CMD_READ_STAT, ZERO_BYTE, ZERO_BYTE}, 1'b0);
        new_status();
        push_frame({PREAMBLE_BYTE, CMD_READ_STAT, ZERO_BYTE, ZERO_BYTE, ZERO_BYTE}, 5);
        isp_programmer_i.spi_frame({PREAMBLE_BYTE, CMD_READ_STAT, ZERO_BYTE, ZERO_BYTE, ZERO_BYTE}, 5);
        drain();
        core_busy = 1'b1;
        repeat (6) @(posedge clock);
        #2 check("busy", {8'h00, busy_output_pin}, 9'h000);
        core_busy = 1'b0;
        repeat (3) @(posedge clock);
        #2 check("busy_off", {8'h00, busy_output_pin}, 9'h001);
        repeat (BUSY_CYCLES) @(posedge clock);
        #2;
        push_frame({8'h00, PREAMBLE_BYTE, CMD_WRITE_FUSE, ZERO_BYTE, 8'hfe}, 4);
        isp_programmer_i.spi_frame({8'h00, PREAMBLE_BYTE, CMD_WRITE_FUSE, ZERO_BYTE, 8'hfe}, 4);
        drain();
        check("isp_pend", {8'h00, isp_enabled}, 9'h001);
        power_cycle();
        check("isp_off", {8'h00, isp_enabled}, 9'h000);
        isp_programmer_i.spi_frame({8'h00, PREAMBLE_BYTE, CMD_READ_STAT, ZERO_BYTE, ZERO_BYTE}, 4);
        push_frame({8'h00, PREAMBLE_BYTE, CMD_WRITE_FUSE, ZERO_BYTE, 8'hff}, 4);
        isp_programmer_i.par_frame({PREAMBLE_BYTE, CMD_WRITE_FUSE, ZERO_BYTE, 8'hff}, 1'b0);
        drain();
        power_cycle();
        check("isp_back", {8'h00, isp_enabled}, 9'h001);
        check("left", 9'(exp_cmd.size() + exp_rd.size()), 9'h000);
        isp_programmer_i.park(1'b1);
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #2 check("exit", {7'h00, miso_oe_n, parallel_data_port_oe_n}, 9'h003);
        complete_run();
    end
endmodule
